// ### include/tw_defs.vh
`ifndef TW_DEFS_VH
`define TW_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define TW_OFS_STOPPED 12'h104
`define TW_OFS_RX_BYTE 12'h108
`define TW_OFS_TX_BYTE 12'h11c
`define TW_OFS_ERROR 12'h124
`define TW_OFS_BOUNDARY 12'h138
`define TW_OFS_HOLD 12'h148
`define TW_OFS_LINKS 12'h200
`define TW_OFS_IRQ_SET 12'h304
`define TW_OFS_IRQ_CLR 12'h308

// ****************************************
// event bit positions
// ****************************************
`define TW_NUM_EV 6
`define TW_EV_STOPPED 0
`define TW_EV_RX_BYTE 1
`define TW_EV_TX_BYTE 2
`define TW_EV_ERROR 3
`define TW_EV_BOUNDARY 4
`define TW_EV_HOLD 5

// ****************************************
// link bits and reset values
// ****************************************
`define TW_LINK_HOLD 0
`define TW_LINK_HALT 1
`define TW_NUM_LINK 2
`define TW_RESET_WORD 32'h00000000
`define TW_SCL_IDLE 1'b1

`endif

// ### rtl/tw_sync.v
`timescale 1ns/1ps
`default_nettype none
`include "tw_defs.vh"

// ****************************************
// three-stage pin synchroniser
// ****************************************
module tw_sync
(
	// clock and control
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// pin and result
	input wire pin_i,
	output reg level_o
);

reg stage1;
reg stage2;
reg stage3;

// stage1 feeds only stage2 so metastability cannot leak
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		stage1 <= `TW_SCL_IDLE;
		stage2 <= `TW_SCL_IDLE;
		stage3 <= `TW_SCL_IDLE;
		level_o <= `TW_SCL_IDLE;
	end
	else if (ce_i)
	begin
		stage1 <= pin_i;
		stage2 <= stage1;
		stage3 <= stage2;
		if (stage2 == stage3)
			level_o <= stage3;
	end
end

endmodule // tw_sync

`default_nettype wire

// ### rtl/tw_event_regs.v
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tw_defs.vh"

module tw_event_regs
(
	// clock, reset, enable
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [11:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg wb_ack_o,
	output reg [31:0] wb_dat_o,
	// event pulses from the shift engine
	input wire stop_done_i,
	input wire rx_byte_i,
	input wire tx_byte_i,
	input wire bus_error_i,
	input wire byte_boundary_i,
	// engine status
	input wire read_mode_i,
	input wire ack_slot_i,
	// task pulses from the task registers
	input wire task_stop_i,
	input wire task_suspend_i,
	input wire task_resume_i,
	// link clock pin
	input wire scl_i,
	// outputs to engine and cpu
	output reg stop_req_o,
	output reg hold_o,
	output wire irq_o
);

// ****************************************
// state encoding
// ****************************************
localparam ST_RUN = 2'b00;
localparam ST_ARMED = 2'b01;
localparam ST_HELD = 2'b10;

// ****************************************
// declarations
// ****************************************
reg [`TW_NUM_EV-1:0] ev_flag;
reg [`TW_NUM_EV-1:0] irq_en;
reg [`TW_NUM_LINK-1:0] links;
reg [1:0] state;
reg [1:0] next_state;
reg scl_prev;
reg [31:0] next_rdata;
reg [`TW_NUM_EV-1:0] ev_hit;
reg [`TW_NUM_EV-1:0] ev_wsel;
wire scl_level;
wire scl_fall;
wire req;
wire wr_commit;
wire suspend_trig;
wire stop_trig;
wire hold_event;
integer i;

// ****************************************
// link clock sampling
// ****************************************
tw_sync u_scl_sync
(
	.clk_i(clk_i),
	.rst_i(rst_i),
	.ce_i(ce_i),
	.pin_i(scl_i),
	.level_o(scl_level)
);

always @(posedge clk_i)
begin
	if (rst_i)
		scl_prev <= `TW_SCL_IDLE;
	else if (ce_i)
		scl_prev <= scl_level;
end

// falling scl closes the ack bit
assign scl_fall = scl_prev & ~scl_level;

// ****************************************
// bus handshake
// ****************************************
assign req = wb_cyc_i & wb_stb_i;
// writes land on the edge the master samples ack
assign wr_commit = wb_ack_o & req & wb_we_i & wb_sel_i[0];

always @(posedge clk_i)
begin
	if (rst_i)
		wb_ack_o <= 1'b0;
	else if (ce_i)
		wb_ack_o <= req & ~wb_ack_o;
end

// ****************************************
// task triggers and shortcuts
// ****************************************
assign suspend_trig = task_suspend_i | (byte_boundary_i & links[`TW_LINK_HOLD]);
assign stop_trig = task_stop_i | (byte_boundary_i & links[`TW_LINK_HALT]);

// suspension only bites at the end of a read ack bit
assign hold_event = (state == ST_ARMED) & read_mode_i & ack_slot_i & scl_fall;

always @*
begin
	next_state = state;
	case (state)
		ST_RUN:
		begin
			if (suspend_trig & ~stop_trig)
				next_state = ST_ARMED;
		end
		ST_ARMED:
		begin
			if (stop_trig | task_resume_i)
				next_state = ST_RUN;
			else if (hold_event)
				next_state = ST_HELD;
		end
		ST_HELD:
		begin
			// resume continues, stop abandons the paused transfer
			if (task_resume_i | stop_trig)
				next_state = ST_RUN;
		end
		default:
			next_state = ST_RUN;
	endcase
end

always @(posedge clk_i)
begin
	if (rst_i)
	begin
		state <= ST_RUN;
		hold_o <= 1'b0;
		stop_req_o <= 1'b0;
	end
	else if (ce_i)
	begin
		state <= next_state;
		hold_o <= (next_state == ST_HELD);
		stop_req_o <= stop_trig;
	end
end

// ****************************************
// event flags
// ****************************************
always @*
begin
	ev_hit = {`TW_NUM_EV{1'b0}};
	ev_hit[`TW_EV_STOPPED] = stop_done_i;
	ev_hit[`TW_EV_RX_BYTE] = rx_byte_i;
	ev_hit[`TW_EV_TX_BYTE] = tx_byte_i;
	ev_hit[`TW_EV_ERROR] = bus_error_i;
	ev_hit[`TW_EV_BOUNDARY] = byte_boundary_i;
	ev_hit[`TW_EV_HOLD] = hold_event;
end

always @*
begin
	ev_wsel = {`TW_NUM_EV{1'b0}};
	case (wb_adr_i)
		`TW_OFS_STOPPED: ev_wsel[`TW_EV_STOPPED] = 1'b1;
		`TW_OFS_RX_BYTE: ev_wsel[`TW_EV_RX_BYTE] = 1'b1;
		`TW_OFS_TX_BYTE: ev_wsel[`TW_EV_TX_BYTE] = 1'b1;
		`TW_OFS_ERROR: ev_wsel[`TW_EV_ERROR] = 1'b1;
		`TW_OFS_BOUNDARY: ev_wsel[`TW_EV_BOUNDARY] = 1'b1;
		`TW_OFS_HOLD: ev_wsel[`TW_EV_HOLD] = 1'b1;
		default: ev_wsel = {`TW_NUM_EV{1'b0}};
	endcase
end

// a new event beats a software write in the same cycle
always @(posedge clk_i)
begin
	if (rst_i)
		ev_flag <= {`TW_NUM_EV{1'b0}};
	else if (ce_i)
	begin
		for (i = 0; i < `TW_NUM_EV; i = i + 1)
		begin
			if (ev_hit[i])
				ev_flag[i] <= 1'b1;
			else if (wr_commit & ev_wsel[i])
				ev_flag[i] <= wb_dat_i[0];
		end
	end
end

// ****************************************
// links and interrupt enables
// ****************************************
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		links <= {`TW_NUM_LINK{1'b0}};
		irq_en <= {`TW_NUM_EV{1'b0}};
	end
	else if (ce_i)
	begin
		if (wr_commit & (wb_adr_i == `TW_OFS_LINKS))
			links <= wb_dat_i[`TW_NUM_LINK-1:0];
		if (wr_commit & (wb_adr_i == `TW_OFS_IRQ_SET))
			irq_en <= irq_en | wb_dat_i[`TW_NUM_EV-1:0];
		else if (wr_commit & (wb_adr_i == `TW_OFS_IRQ_CLR))
			irq_en <= irq_en & ~wb_dat_i[`TW_NUM_EV-1:0];
	end
end

assign irq_o = |(ev_flag & irq_en);

// ****************************************
// read mux
// ****************************************
always @*
begin
	next_rdata = `TW_RESET_WORD;
	case (wb_adr_i)
		`TW_OFS_STOPPED: next_rdata[0] = ev_flag[`TW_EV_STOPPED];
		`TW_OFS_RX_BYTE: next_rdata[0] = ev_flag[`TW_EV_RX_BYTE];
		`TW_OFS_TX_BYTE: next_rdata[0] = ev_flag[`TW_EV_TX_BYTE];
		`TW_OFS_ERROR: next_rdata[0] = ev_flag[`TW_EV_ERROR];
		`TW_OFS_BOUNDARY: next_rdata[0] = ev_flag[`TW_EV_BOUNDARY];
		`TW_OFS_HOLD: next_rdata[0] = ev_flag[`TW_EV_HOLD];
		`TW_OFS_LINKS: next_rdata[`TW_NUM_LINK-1:0] = links;
		`TW_OFS_IRQ_SET: next_rdata[`TW_NUM_EV-1:0] = irq_en;
		`TW_OFS_IRQ_CLR: next_rdata[`TW_NUM_EV-1:0] = irq_en;
		default: next_rdata = `TW_RESET_WORD;
	endcase
end

// data captured with ack so it stands for the whole ack cycle
always @(posedge clk_i)
begin
	if (rst_i)
		wb_dat_o <= `TW_RESET_WORD;
	else if (ce_i & req & ~wb_ack_o)
		wb_dat_o <= next_rdata;
end

endmodule // tw_event_regs

`default_nettype wire

// ### test/tw_far.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// slave side: one read byte and its ack
// ****************
module tw_far
(
	// frame start
	input wire logic go_i,
	// bus side
	output logic scl_o,
	output logic rd_o,
	output logic ack_o
);
	// scl pulled up, so it stands high between frames
	initial
	begin
		scl_o = 1'b1;
		rd_o = 1'b0;
		ack_o = 1'b0;
	end
	// pin edges kept off the clock edges; ack slot opens only after
	// the synchronised fall of the last data bit has gone by
	always @(posedge go_i)
	begin
		#10;
		rd_o = 1'b1;
		for (int i = 0; i < 9; i++)
		begin
			#100 ack_o = (i == 8);
			#100 scl_o = 1'b0;
			#200 scl_o = 1'b1;
		end
		// keep ack up past the synchroniser delay
		#200;
		ack_o = 1'b0;
		rd_o = 1'b0;
	end
endmodule // tw_far
`default_nettype wire

// ### test/tw_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// port checker
// ****************
module tw_chk
(
	// clock and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// engine and tasks
	input wire logic stop_done_i,
	input wire logic rx_byte_i,
	input wire logic tx_byte_i,
	input wire logic bus_error_i,
	input wire logic byte_boundary_i,
	input wire logic read_mode_i,
	input wire logic ack_slot_i,
	input wire logic task_stop_i,
	input wire logic task_resume_i,
	// outputs
	input wire logic stop_req_o,
	input wire logic hold_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	chk_read_width: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:6] == 26'h0) else $error("high bits");
	chk_stop_task: assert property (task_stop_i |=> stop_req_o) else $error("stop lost");
	chk_stop_cause: assert property (stop_req_o |-> $past(task_stop_i || byte_boundary_i)) else $error("stray stop");
	chk_hold_cause: assert property ($rose(hold_o) |-> $past(read_mode_i && ack_slot_i)) else $error("bad hold");
	chk_hold_leave: assert property (hold_o && (task_resume_i || task_stop_i) |-> ##[1:2] !hold_o)
		else $error("hold stuck");
	chk_irq_cause: assert property ($rose(irq_o) |-> $rose(hold_o) || $past(stop_done_i || rx_byte_i || tx_byte_i
		|| bus_error_i || byte_boundary_i || wb_ack_o && wb_we_i)) else $error("stray irq");
	cover property ($rose(hold_o));
	cover property (stop_req_o);
	cover property ($rose(irq_o));
endmodule // tw_chk
bind tw_event_regs tw_chk u_chk
(
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_ack_o(wb_ack_o),
	.wb_dat_o(wb_dat_o),
	.stop_done_i(stop_done_i),
	.rx_byte_i(rx_byte_i),
	.tx_byte_i(tx_byte_i),
	.bus_error_i(bus_error_i),
	.byte_boundary_i(byte_boundary_i),
	.read_mode_i(read_mode_i),
	.ack_slot_i(ack_slot_i),
	.task_stop_i(task_stop_i),
	.task_resume_i(task_resume_i),
	.stop_req_o(stop_req_o),
	.hold_o(hold_o),
	.irq_o(irq_o)
);
`default_nettype wire

// ### test/tw_event_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "tw_defs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("wrong value %0t %h", $time, a); end end
// ****************
// bench
// ****************
module tw_event_regs_test;
	logic clk_i = '0, rst_i = '1, cyc = '0, we = '0, ce = '1;
	logic [11:0] adr = '0;
	logic [31:0] wdat = '0, rd, e, seed = 32'hd01c;
	logic [8:0] s = '0;
	wire ack, stp, hold, irq, scl, rdm, aks;
	wire [31:0] dat_o;
	int num_errors = 0, total_checks = 0;
	logic [11:0] rg [10] = '{`TW_OFS_STOPPED, `TW_OFS_RX_BYTE, `TW_OFS_TX_BYTE, `TW_OFS_ERROR, `TW_OFS_BOUNDARY,
		`TW_OFS_HOLD, `TW_OFS_LINKS, `TW_OFS_IRQ_SET, `TW_OFS_IRQ_CLR, 12'h010};
	tw_event_regs DUT(.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(dat_o), .stop_done_i(s[0]),
		.rx_byte_i(s[1]), .tx_byte_i(s[2]), .bus_error_i(s[3]), .byte_boundary_i(s[4]), .read_mode_i(rdm),
		.ack_slot_i(aks), .task_stop_i(s[5]), .task_resume_i(s[6]), .task_suspend_i(s[8]), .scl_i(scl),
		.stop_req_o(stp), .hold_o(hold), .irq_o(irq));
	tw_far far(.go_i(s[7]), .scl_o(scl), .rd_o(rdm), .ack_o(aks));
	initial
		forever #25 clk_i = ~clk_i;
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [31:0] en_after(input logic [31:0] old, w, input logic clr);
		return clr ? old & ~w & 32'h3f : (old | w) & 32'h3f;
	endfunction
	task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic pul(input int i);
		@(posedge clk_i);
		s <= 9'h1 << i;
		@(posedge clk_i);
		s <= '0;
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// about four and a half times what the sequence needs
	initial
	begin
		#100000;
		num_errors++;
		report_and_stop();
	end
	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 10; i++)
		begin
			wb(1'b0, rg[i], '0);
			`CHK(rd, 32'h0)
		end
		$display("reset values done");
		e = '0;
		repeat (8)
		begin
			seed = lfsr(seed);
			wb(1'b1, seed[9] ? `TW_OFS_IRQ_CLR : `TW_OFS_IRQ_SET, seed);
			e = en_after(e, seed, seed[9]);
			wb(1'b0, rg[seed[3] ? 8 : 7], '0);
			`CHK(rd, e)
		end
		wb(1'b1, `TW_OFS_IRQ_CLR, 32'h3f);
		// frozen clock enable must swallow an event pulse
		@(posedge clk_i);
		ce <= 1'b0;
		s <= 9'h2;
		@(posedge clk_i);
		ce <= 1'b1;
		s <= '0;
		wb(1'b0, `TW_OFS_RX_BYTE, '0);
		`CHK(rd, 32'h0)
		$display("enables done");
		for (int i = 0; i < 5; i++)
		begin
			pul(i);
			wb(1'b0, rg[i], '0);
			`CHK({rd, irq}, {32'h1, 1'b0})
			wb(1'b1, `TW_OFS_IRQ_SET, 32'h1 << i);
			@(negedge clk_i);
			`CHK(irq, 1'b1)
			wb(1'b1, rg[i], '0);
			@(negedge clk_i);
			`CHK(irq, 1'b0)
			wb(1'b1, `TW_OFS_IRQ_CLR, 32'h3f);
		end
		$display("events done");
		wb(1'b1, `TW_OFS_LINKS, 32'h2);
		for (int k = 4; k < 6; k++)
		begin
			pul(k);
			@(negedge clk_i);
			`CHK(stp, 1'b1)
		end
		// third frame: no suspend asked, so no hold
		for (int f = 0; f < 3; f++)
		begin
			wb(1'b1, `TW_OFS_LINKS, {31'h0, f == 1});
			pul(f == 0 ? 8 : 4);
			pul(7);
			wait (rdm);
			wait (!rdm);
			wb(1'b0, `TW_OFS_HOLD, '0);
			`CHK({rd[0], hold}, {2{f < 2}})
			pul(f == 0 ? 6 : 5);
			repeat (2) @(negedge clk_i);
			`CHK(hold, 1'b0)
			wb(1'b1, `TW_OFS_HOLD, '0);
		end
		$display("links and hold done");
		report_and_stop();
	end
endmodule // tw_event_regs_test
`default_nettype wire
